// ---- src/eeprom_cfg.svh ----
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH
`define EE_ARRAY_BITS      16384
`define EE_BYTE_AW         11
`define EE_WORD_AW         10
`define EE_OP_READ         2'b10
`define EE_OP_WRITE        2'b01
`define EE_OP_ERASE        2'b11
`define EE_OP_EXT          2'b00
`define EE_EXT_LOCK        2'b00
`define EE_EXT_FILL        2'b01
`define EE_EXT_CLEAR       2'b10
`define EE_EXT_UNLOCK      2'b11
`define EE_ERASED_BYTE     8'hFF
`define EE_PROG_TIME_US    4
`define EE_CLK_MHZ         100
`define EE_PROG_CYCLES     (`EE_PROG_TIME_US * `EE_CLK_MHZ)
`endif

// ---- src/eeprom_pkg.sv ----
package eeprom_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_OPC   = 3'b001,
    ST_ADDR  = 3'b010,
    ST_DATA  = 3'b011,
    ST_READ  = 3'b100,
    ST_PROG  = 3'b101,
    ST_DONE  = 3'b110
  } ee_state_e;
  typedef logic [1:0] opcode_t;
endpackage : eeprom_pkg

// ---- src/serial_eeprom_device_core.sv ----
`include "eeprom_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_device_core #(
  parameter int PROG_CYCLES = `EE_PROG_CYCLES
) (
  input  wire logic i_clk,           // system clock
  input  wire logic i_reset_n,       // power-on reset, active low
  input  wire logic i_select,        // chip select pin
  input  wire logic i_sclk,          // serial clock pin
  input  wire logic i_sdi,           // serial data in pin
  input  wire logic i_layout_select, // 1 words, 0 bytes
  output var  logic o_sdo,           // serial data out
  output var  logic o_sdo_oe,        // data out enable
  output var  logic o_busy           // programming in progress
);
  import eeprom_pkg::*;

  localparam int AW = `EE_BYTE_AW;
  localparam int NB = `EE_ARRAY_BITS / 8;
  // bulk sweeps write one byte a cycle, so they stay busy for at least a full pass
  localparam int BULK_CYCLES = (PROG_CYCLES > NB) ? PROG_CYCLES : NB;

  logic [7:0] mem [NB];
  logic [2:0] sel_s, clk_s, din_s;
  logic       sel, sclk, din, sclk_prev, rise, fall;
  ee_state_e  st_q;
  logic [4:0] cnt_q;
  opcode_t    op_q;
  logic [AW-1:0] addr_q;
  logic [15:0] data_q, shreg_q;
  logic       unlock_q;
  logic       word_q;
  logic [$clog2(BULK_CYCLES+1)-1:0] prog_q;
  logic [1:0] pkind_q;   // 0 single, 1 fill, 2 clear
  logic [AW-1:0] pidx_q;
  logic [15:0] pdata_q;
  logic [15:0] pword_q;
  logic [AW:0] fill_q;

  function automatic logic [4:0] addr_len(input logic w);
    addr_len = w ? 5'(`EE_WORD_AW) : 5'(`EE_BYTE_AW);
  endfunction : addr_len

  // three-stage sampling; change counts when stages two and three agree
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_s <= '0;
      clk_s <= '0;
      din_s <= '0;
      sel <= 1'b0;
      sclk <= 1'b0;
      din <= 1'b0;
      sclk_prev <= 1'b0;
    end else begin
      sel_s <= {sel_s[1:0], i_select};
      clk_s <= {clk_s[1:0], i_sclk};
      din_s <= {din_s[1:0], i_sdi};
      if (sel_s[1] == sel_s[2]) sel <= sel_s[2];
      if (clk_s[1] == clk_s[2]) sclk <= clk_s[2];
      if (din_s[1] == din_s[2]) din <= din_s[2];
      sclk_prev <= sclk;
    end
  end

  assign rise = sclk & ~sclk_prev;
  assign fall = ~sclk & sclk_prev;

  logic prog_run;
  assign prog_run = (st_q == ST_PROG) || (st_q == ST_DONE && prog_q != '0);

  // received data words queue here on their way to the program engine
  logic        fifo_push;
  logic        fifo_room;
  logic        fifo_valid;
  logic        fifo_pop;
  logic [15:0] fifo_data;
  assign fifo_push = sel && st_q == ST_DATA && rise && cnt_q == 5'd1 && fifo_room;
  assign fifo_pop  = st_q == ST_PROG && fifo_valid;

  ee_word_fifo #(
    .WIDTH(16),
    .DEPTH(4)
  ) word_fifo_u (
    .i_clk      (i_clk),
    .i_reset_n  (i_reset_n),
    .i_in_valid (fifo_push),
    .o_in_ready (fifo_room),
    .i_in_data  ({data_q[14:0], din}),
    .o_out_valid(fifo_valid),
    .i_out_ready(fifo_pop),
    .o_out_data (fifo_data)
  );

  // instruction sequencer
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      op_q <= '0;
      addr_q <= '0;
      data_q <= '0;
      shreg_q <= '0;
      unlock_q <= 1'b0;
      word_q <= 1'b1;
      pkind_q <= '0;
      pdata_q <= '0;
    end else if (!sel && st_q != ST_PROG) begin
      st_q <= (st_q == ST_DONE && prog_run) ? ST_DONE : ST_IDLE;
      cnt_q <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          word_q <= i_layout_select;
          if (rise && din) begin
            st_q <= ST_OPC;
            cnt_q <= 5'd2;
          end
        end
        ST_OPC: if (rise) begin
          op_q <= {op_q[0], din};
          cnt_q <= cnt_q - 5'd1;
          if (cnt_q == 5'd1) begin
            st_q <= ST_ADDR;
            cnt_q <= addr_len(word_q);
            addr_q <= '0;
          end
        end
        ST_ADDR: if (rise) begin
          addr_q <= {addr_q[AW-2:0], din};
          cnt_q <= cnt_q - 5'd1;
          if (cnt_q == 5'd1) begin
            logic [AW-1:0] a;
            logic [1:0] ext;
            a = {addr_q[AW-2:0], din};
            ext = word_q ? a[`EE_WORD_AW-1 -: 2] : a[AW-1 -: 2];
            cnt_q <= word_q ? 5'd16 : 5'd8;
            addr_q <= a;
            st_q <= ST_IDLE;
            case (op_q)
              `EE_OP_READ: begin
                st_q <= ST_READ;
                cnt_q <= 5'd0;
              end
              `EE_OP_WRITE: st_q <= unlock_q ? ST_DATA : ST_IDLE;
              `EE_OP_ERASE: if (unlock_q) begin
                pkind_q <= 2'd0;
                pdata_q <= 16'hFFFF;
                st_q <= ST_PROG;
              end
              default: case (ext)
                `EE_EXT_LOCK:   unlock_q <= 1'b0;
                `EE_EXT_UNLOCK: unlock_q <= 1'b1;
                `EE_EXT_FILL:   st_q <= unlock_q ? ST_DATA : ST_IDLE;
                default: if (unlock_q) begin
                  pkind_q <= 2'd2;
                  pdata_q <= 16'hFFFF;
                  st_q <= ST_PROG;
                end
              endcase
            endcase
          end
        end
        ST_DATA: if (rise) begin
          data_q <= {data_q[14:0], din};
          cnt_q <= cnt_q - 5'd1;
          if (cnt_q == 5'd1) begin
            pkind_q <= (op_q == `EE_OP_WRITE) ? 2'd0 : 2'd1;
            st_q <= ST_PROG;
          end
        end
        ST_READ: if (fall) begin
          if (cnt_q == 5'd0) begin
            shreg_q <= word_q ? {mem[{addr_q[`EE_WORD_AW-1:0], 1'b1}], mem[{addr_q[`EE_WORD_AW-1:0], 1'b0}]}
                              : {mem[addr_q], 8'h00};
            cnt_q <= word_q ? 5'd15 : 5'd7;
            if (word_q)
              addr_q <= (addr_q[`EE_WORD_AW-1:0] == '1) ? '0 : addr_q + 1'b1;
            else
              addr_q <= addr_q + 1'b1;
          end else begin
            shreg_q <= {shreg_q[14:0], 1'b0};
            cnt_q <= cnt_q - 5'd1;
          end
        end
        ST_PROG: st_q <= ST_DONE;
        ST_DONE: st_q <= ST_DONE;                        // ready holds until deselect
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // self-timed program engine runs from i_clk only
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      prog_q <= '0;
      pidx_q <= '0;
      fill_q <= '0;
      pword_q <= '0;
    end else if (st_q == ST_PROG) begin
      prog_q <= (pkind_q == 2'd0) ? ($bits(prog_q))'(PROG_CYCLES) : ($bits(prog_q))'(BULK_CYCLES);
      pidx_q <= addr_q;
      fill_q <= '0;
      pword_q <= fifo_valid ? fifo_data : pdata_q;
    end else if (prog_q != '0) begin
      prog_q <= prog_q - 1'b1;
      if (pkind_q != 2'd0 && fill_q <= (AW+1)'(NB - 1)) fill_q <= fill_q + 1'b1;
    end
  end

  // array update: single writes land once, bulk ops sweep one byte a cycle
  always_ff @(posedge i_clk) begin
    if (prog_q == ($bits(prog_q))'(PROG_CYCLES) && pkind_q == 2'd0) begin
      if (word_q) begin
        mem[{pidx_q[`EE_WORD_AW-1:0], 1'b0}] <= pword_q[7:0];
        mem[{pidx_q[`EE_WORD_AW-1:0], 1'b1}] <= pword_q[15:8];
      end else
        mem[pidx_q] <= pword_q[7:0];
    end else if (prog_q != '0 && pkind_q != 2'd0 && fill_q <= (AW+1)'(NB - 1)) begin
      mem[fill_q[AW-1:0]] <= (word_q && fill_q[0]) ? pword_q[15:8] : pword_q[7:0];
    end
  end

  // output pin; ready shows once the timer drains
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_sdo <= 1'b0;
      o_sdo_oe <= 1'b0;
      o_busy <= 1'b0;
    end else begin
      o_busy <= prog_run;
      o_sdo_oe <= sel && (st_q == ST_READ || st_q == ST_DONE);
      o_sdo <= (st_q == ST_DONE) ? !prog_run : shreg_q[15];
    end
  end

  // the three-cycle bound keeps the busy window checkable without deep unrolling
  property deselect_float;
    @(posedge i_clk) disable iff (!i_reset_n) !sel |=> !o_sdo_oe;
  endproperty
  output_float_a:  assert property (deselect_float) else $error("data out driven while deselected");
  reset_idle_a:    assert property (@(posedge i_clk) $rose(i_reset_n) |-> st_q == ST_IDLE && !unlock_q)
    else $error("not idle after reset");
  locked_noprog_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_ADDR && !unlock_q && op_q != `EE_OP_READ) |=> st_q != ST_PROG)
    else $error("program while locked");
  sequence prog_start_s;
    st_q == ST_PROG;
  endsequence
  prog_busy_a:     assert property (@(posedge i_clk) disable iff (!i_reset_n)
    prog_start_s |=> ##1 o_busy[*3])
    else $error("busy not raised");
  busy_report_a:   assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (o_sdo_oe && st_q == ST_DONE && $past(prog_run) && prog_run) |-> !o_sdo)
    else $error("ready shown while busy");
  start_bit_a:     assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_IDLE && sel && rise && din) |=> st_q == ST_OPC && cnt_q == 5'd2)
    else $error("start bit missed");
  opcode_len_a:    assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_OPC && sel && rise && cnt_q == 5'd1) |=> cnt_q == addr_len(word_q))
    else $error("address length wrong");
  read_incr_a:     assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_READ && sel && fall && cnt_q == 5'd0 && !word_q) |=> addr_q == $past(addr_q) + 1'b1)
    else $error("address not incremented");
  prog_word_a:     assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_PROG && pkind_q != 2'd2 && op_q != `EE_OP_ERASE) |-> fifo_valid)
    else $error("program word missing");
  ready_hold_a:    assert property (@(posedge i_clk) disable iff (!i_reset_n)
    (st_q == ST_DONE && sel && !prog_run) |=> st_q == ST_DONE)
    else $error("ready dropped while selected");
endmodule : serial_eeprom_device_core

// small queue with valid and ready on both sides
module ee_word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clk,       // system clock
  input  wire logic             i_reset_n,   // async reset, active low
  input  wire logic             i_in_valid,  // push request
  output var  logic             o_in_ready,  // room for one more word
  input  wire logic [WIDTH-1:0] i_in_data,   // word pushed
  output var  logic             o_out_valid, // a word is waiting
  input  wire logic             i_out_ready, // pop request
  output var  logic [WIDTH-1:0] o_out_data   // oldest word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] slot_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      used_q;
  logic             push;
  logic             pop;

  // pointers wrap at DEPTH, which need not be a power of two
  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
    next_ptr = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : next_ptr

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign o_in_ready  = used_q < (PW+1)'(DEPTH);
  assign o_out_valid = used_q != '0;
  assign o_out_data  = slot_q[rd_q];

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= next_ptr(wr_q);
      if (pop) rd_q <= next_ptr(rd_q);
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      used_q <= '0;
    end else begin
      used_q <= used_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // storage needs no reset: nothing is read before it is written
  always_ff @(posedge i_clk) begin
    if (push) slot_q[wr_q] <= i_in_data;
  end

  fifo_bound_a: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    used_q <= (PW+1)'(DEPTH))
    else $error("queue count out of range");
endmodule : ee_word_fifo
`default_nettype wire

// ---- tb/eeprom_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module eeprom_master (
  output var  logic o_select, // chip select to the device
  output var  logic o_sclk,   // serial clock, still between frames
  output var  logic o_sdi,    // serial data to the device
  input  wire logic i_sdo     // resolved data line from the device
);
  initial begin
    o_select = 1'b0;
    o_sclk   = 1'b0;
    o_sdi    = 1'b0;
  end

  // data moves while sclk is low; the answer is taken at the rise
  task automatic clk_bit(input logic b, output logic q);
    o_sdi <= b;
    #62.5 o_sclk <= 1'b1;
    q = i_sdo;
    #62.5 o_sclk <= 1'b0;
  endtask : clk_bit

  task automatic sel_on;
    o_select <= 1'b1;
    #100;
  endtask : sel_on

  // one device only, left deselected and idle between uses
  task automatic sel_off;
    o_select <= 1'b0;
    #150;
  endtask : sel_off

  task automatic frame(input logic [1:0] op, input logic [10:0] a, input int an,
                       input logic [15:0] d, input int dn);
    logic q;
    sel_on();
    clk_bit(1'b1, q);
    for (int i = 1; i >= 0; i--) clk_bit(op[i], q);
    for (int i = an - 1; i >= 0; i--) clk_bit(a[i], q);
    for (int i = dn - 1; i >= 0; i--) clk_bit(d[i], q);
  endtask : frame

  // sdi keeps toggling while the device talks, never a stale level
  task automatic get(input int n, output logic [15:0] v);
    logic q;
    v = 16'h0000;
    for (int i = 0; i < n; i++) begin
      clk_bit(~o_sdi, q);
      v = {v[14:0], q};
    end
  endtask : get
endmodule : eeprom_master
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic layout = 1'b0;
  logic sdo, sdo_oe, busy;
  wire  logic sel, sclk, sdi, sdo_line;
  int   fails = 0;
  int   cmp_count = 0;
  int   cyc = 0;

  always #5 clk = ~clk;
  // no pull on the data line: an undriven line shows the inverse
  assign sdo_line = sdo_oe ? sdo : ~sdo;

  serial_eeprom_device_core #(.PROG_CYCLES(40)) dut_u (.i_clk(clk), .i_reset_n(reset_n), .i_select(sel),
    .i_sclk(sclk), .i_sdi(sdi), .i_layout_select(layout), .o_sdo(sdo), .o_sdo_oe(sdo_oe), .o_busy(busy));
  eeprom_master host_u (.o_select(sel), .o_sclk(sclk), .o_sdi(sdi), .i_sdo(sdo_line));

  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  function automatic int aw(); return layout ? 10 : 11; endfunction : aw
  function automatic int dw(); return layout ? 16 : 8; endfunction : dw

  // prog says whether a self-timed cycle must follow the frame
  task automatic op(input logic [1:0] oc, input logic [10:0] a, input logic [15:0] d, input int dn,
                    input logic prog);
    int n;
    host_u.frame(oc, a, aw(), d, dn);
    host_u.sel_off();
    check("busy flag", 16'(busy), 16'(prog));
    host_u.sel_on();
    check("status enable", 16'(sdo_oe), 16'(prog));
    if (prog) begin
      check("status level", 16'(sdo_line), 16'h0000);
      n = 0;
      while (sdo_line !== 1'b1 && n < 3000) begin
        @(posedge clk);
        n++;
      end
      check("ready level", 16'(sdo_line), 16'h0001);
    end
    host_u.sel_off();
    check("idle enable", 16'(sdo_oe), 16'h0000);
  endtask : op

  task automatic ext(input logic [1:0] code, input logic [15:0] d, input logic prog);
    op(2'b00, 11'(code) << (aw() - 2), d, (code == 2'b01) ? dw() : 0, prog);
  endtask : ext

  task automatic rd(input logic [10:0] a, input logic [15:0] e0, input logic [15:0] e1);
    logic [15:0] v;
    host_u.frame(2'b10, a, aw(), 16'h0000, 0);
    host_u.get(dw(), v);
    check("read data", v, e0);
    host_u.get(dw(), v);
    check("next data", v, e1);
    host_u.sel_off();
    check("read release enable", 16'(sdo_oe), 16'h0000);
  endtask : rd

  task automatic set_layout(input logic w);
    layout <= w;
    repeat (4) @(posedge clk);
  endtask : set_layout

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      fails++;
      report_and_stop();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("standby enable", 16'(sdo_oe), 16'h0000);
    check("standby busy", 16'(busy), 16'h0000);
    op(2'b01, 11'h005, 16'h00A5, 8, 1'b0);
    ext(2'b11, 16'h0000, 1'b0);
    ext(2'b10, 16'h0000, 1'b1);
    rd(11'h005, 16'h00FF, 16'h00FF);
    op(2'b01, 11'h005, 16'h003C, 8, 1'b1);
    op(2'b01, 11'h005, 16'h00C3, 8, 1'b1);
    rd(11'h004, 16'h00FF, 16'h00C3);
    rd(11'h005, 16'h00C3, 16'h00FF);
    op(2'b01, 11'h7FF, 16'h005A, 8, 1'b1);
    op(2'b01, 11'h000, 16'h0011, 8, 1'b1);
    rd(11'h7FF, 16'h005A, 16'h0011);
    op(2'b11, 11'h005, 16'h0000, 0, 1'b1);
    rd(11'h004, 16'h00FF, 16'h00FF);
    set_layout(1'b1);
    op(2'b01, 11'h003, 16'hBEEF, 16, 1'b1);
    rd(11'h003, 16'hBEEF, 16'hFFFF);
    set_layout(1'b0);
    rd(11'h006, 16'h00EF, 16'h00BE);
    set_layout(1'b1);
    ext(2'b01, 16'hAA55, 1'b1);
    rd(11'h3FF, 16'hAA55, 16'hAA55);
    ext(2'b00, 16'h0000, 1'b0);
    op(2'b01, 11'h000, 16'h1234, 16, 1'b0);
    rd(11'h000, 16'hAA55, 16'hAA55);
    ext(2'b11, 16'h0000, 1'b0);
    @(posedge clk);
    reset_n <= 1'b0;
    host_u.frame(2'b01, 11'h000, 10, 16'h0000, 16);
    host_u.sel_off();
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (8) @(posedge clk);
    check("reset busy", 16'(busy), 16'h0000);
    check("reset enable", 16'(sdo_oe), 16'h0000);
    op(2'b01, 11'h000, 16'h0000, 16, 1'b0);
    rd(11'h000, 16'hAA55, 16'hAA55);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
